/* src/pdmac_top.sv */
/*
 Peripheral DMA channel pair: receive and transmit channels with chained
 buffers, an AHB-Lite register slave and a simple memory master port.
 Assumes the peripheral's ready triggers and data come from logic on the
 same clock, and a single-transfer memory port with a ready handshake.
*/
// Summary of operation
// - Receive counter holds transfers still to do
// - 32-bit transmit pointer addresses next fetch
// - Transmit stops while its counter is zero
// - Receive next pointer names following buffer
// - Receive next counter, bits 15 to 0
// - Transmit next pointer names following buffer
// - Transmit next counter, bits 15 to 0
// - Write-only control bits 0,1,8,9; zeros ignored
// - Receive enable only without receive disable
// - Receive disable turns receive requests off
// - Transmit enable turns transmit requests on
// - Transmit disable turns transmit requests off
// - Status bit 0 shows receive enable
// - Status bit 8 shows transmit enable
// - Pointer steps 1,2,4; counter decrements
// - At zero reload next pair if next counter nonzero, clear next counter
// - Done flag at zero, exhausted when both zero
// - Counter writes clear that direction's done flag
`timescale 1ns/1ps
module pdmac_top
	import pdmac_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic HREADY_I,
	input wire logic [31:0] HWDATA_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic RX_READY_I,
	input wire logic [31:0] RX_DATA_I,
	output logic RX_TAKE_O,
	input wire logic TX_READY_I,
	output logic [31:0] TX_DATA_O,
	output logic TX_LOAD_O,
	output logic [31:0] M_ADDR_O,
	output logic M_WRITE_O,
	output logic [1:0] M_SIZE_O,
	output logic M_REQ_O,
	output logic [31:0] M_WDATA_O,
	input wire logic [31:0] M_RDATA_I,
	input wire logic M_DONE_I,
	output logic RX_DONE_O,
	output logic RX_EXH_O,
	output logic TX_DONE_O,
	output logic TX_EXH_O
);
	// Pointer step for a transfer size
	function automatic logic [31:0] step_of(input logic [1:0] sz);
		step_of = (sz == PDMAC_SZ_WORD) ? 32'h4 : ((sz == PDMAC_SZ_HALF) ? 32'h2 : 32'h1);
	endfunction

	logic [31:0] rx_ptr_reg, tx_ptr_reg, rx_nptr_reg, tx_nptr_reg;
	logic [15:0] rx_cnt_reg, tx_cnt_reg, rx_ncnt_reg, tx_ncnt_reg;
	logic rx_en_reg, tx_en_reg, rx_done_reg, tx_done_reg;
	logic rx_exh_reg, tx_exh_reg;
	logic [1:0] size_reg;
	logic wr_pend_reg;
	logic [11:0] wr_addr_reg;
	logic [31:0] rdata_reg;
	pdmac_state_e state_reg, state_next;
	logic dir_tx_reg;
	logic [31:0] m_addr_reg, m_wdata_reg, tx_data_reg;
	logic m_req_reg, m_write_reg, rx_take_reg, tx_load_reg;

	// Bus address phase decode
	wire addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];
	wire [11:0] a_off = HADDR_I[11:0];
	wire rd_take = addr_phase && !HWRITE_I;
	wire wr_take = addr_phase && HWRITE_I;
	// Data phase write strobes
	wire w_rx_ptr = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_RX_PTR);
	wire w_rx_cnt = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_RX_CNT);
	wire w_tx_ptr = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_TX_PTR);
	wire w_tx_cnt = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_TX_CNT);
	wire w_rx_nptr = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_RX_NPTR);
	wire w_rx_ncnt = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_RX_NCNT);
	wire w_tx_nptr = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_TX_NPTR);
	wire w_tx_ncnt = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_TX_NCNT);
	wire w_ctrl = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_CTRL);
	wire w_size = wr_pend_reg && (wr_addr_reg == PDMAC_OFF_SIZE);
	wire [15:0] wd_cnt = HWDATA_I[15:0]; // Upper bits dropped

	// Status and flag words
	wire rx_exh = (rx_cnt_reg == PDMAC_CNT_RST) && (rx_ncnt_reg == PDMAC_CNT_RST);
	wire tx_exh = (tx_cnt_reg == PDMAC_CNT_RST) && (tx_ncnt_reg == PDMAC_CNT_RST);
	wire [31:0] stat_word = (32'(rx_en_reg) << PDMAC_BIT_RX_ON) | (32'(tx_en_reg) << PDMAC_BIT_TX_ON);
	wire [31:0] flag_word = (32'(rx_done_reg) << PDMAC_BIT_RX_DONE) | (32'(rx_exh) << PDMAC_BIT_RX_EXH)
		| (32'(tx_done_reg) << PDMAC_BIT_TX_DONE) | (32'(tx_exh) << PDMAC_BIT_TX_EXH);

	// Read mux; control register and unmapped read zero
	wire [31:0] rd_mux =
		(a_off == PDMAC_OFF_RX_PTR) ? rx_ptr_reg :
		(a_off == PDMAC_OFF_RX_CNT) ? {16'h0000, rx_cnt_reg} :
		(a_off == PDMAC_OFF_TX_PTR) ? tx_ptr_reg :
		(a_off == PDMAC_OFF_TX_CNT) ? {16'h0000, tx_cnt_reg} :
		(a_off == PDMAC_OFF_RX_NPTR) ? rx_nptr_reg :
		(a_off == PDMAC_OFF_RX_NCNT) ? {16'h0000, rx_ncnt_reg} :
		(a_off == PDMAC_OFF_TX_NPTR) ? tx_nptr_reg :
		(a_off == PDMAC_OFF_TX_NCNT) ? {16'h0000, tx_ncnt_reg} :
		(a_off == PDMAC_OFF_STAT) ? stat_word :
		(a_off == PDMAC_OFF_SIZE) ? {30'h0, size_reg} :
		(a_off == PDMAC_OFF_FLAGS) ? flag_word : 32'h0000_0000;

	// Control decode: disable wins in both directions
	wire rx_on = w_ctrl && HWDATA_I[PDMAC_BIT_RX_ON] && !HWDATA_I[PDMAC_BIT_RX_OFF];
	wire rx_off = w_ctrl && HWDATA_I[PDMAC_BIT_RX_OFF];
	wire tx_on = w_ctrl && HWDATA_I[PDMAC_BIT_TX_ON] && !HWDATA_I[PDMAC_BIT_TX_OFF];
	wire tx_off = w_ctrl && HWDATA_I[PDMAC_BIT_TX_OFF];

	// Channel requests: enabled, counter nonzero, peripheral ready
	wire rx_want = rx_en_reg && (rx_cnt_reg != PDMAC_CNT_RST) && RX_READY_I;
	wire tx_want = tx_en_reg && (tx_cnt_reg != PDMAC_CNT_RST) && TX_READY_I;
	wire xfer_end = (state_reg == PDMAC_ST_DATA) && M_DONE_I;
	wire rx_end = xfer_end && !dir_tx_reg;
	wire tx_end = xfer_end && dir_tx_reg;
	wire [15:0] rx_cnt_dec = rx_cnt_reg - 16'h0001;
	wire [15:0] tx_cnt_dec = tx_cnt_reg - 16'h0001;
	wire rx_hit0 = rx_end && (rx_cnt_dec == PDMAC_CNT_RST);
	wire tx_hit0 = tx_end && (tx_cnt_dec == PDMAC_CNT_RST);

	// Master engine next state; receive served first
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PDMAC_ST_IDLE: begin
				if (rx_want || tx_want) begin
					state_next = PDMAC_ST_ADDR;
				end
			end
			PDMAC_ST_ADDR: state_next = PDMAC_ST_DATA;
			PDMAC_ST_DATA: begin
				if (M_DONE_I) begin
					state_next = PDMAC_ST_IDLE;
				end
			end
			default: state_next = PDMAC_ST_IDLE;
		endcase
	end

	// Bus slave registers
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
			rdata_reg <= 32'h0000_0000;
		end else begin
			wr_pend_reg <= wr_take;
			wr_addr_reg <= a_off;
			if (rd_take) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	// Enable state
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			rx_en_reg <= 1'b0;
			tx_en_reg <= 1'b0;
		end else begin
			if (rx_off) rx_en_reg <= 1'b0;
			else if (rx_on) rx_en_reg <= 1'b1;
			if (tx_off) tx_en_reg <= 1'b0;
			else if (tx_on) tx_en_reg <= 1'b1;
		end
	end

	// Size setting
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) size_reg <= PDMAC_SZ_RST;
		else if (w_size && (HWDATA_I[1:0] != 2'h3)) size_reg <= HWDATA_I[1:0];
	end

	// Receive channel pointers and counters; hardware step wins over write
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			rx_ptr_reg <= PDMAC_PTR_RST;
			rx_cnt_reg <= PDMAC_CNT_RST;
			rx_nptr_reg <= PDMAC_PTR_RST;
			rx_ncnt_reg <= PDMAC_CNT_RST;
		end else if (rx_hit0 && (rx_ncnt_reg != PDMAC_CNT_RST)) begin
			rx_ptr_reg <= rx_nptr_reg;
			rx_cnt_reg <= rx_ncnt_reg;
			rx_ncnt_reg <= PDMAC_CNT_RST;
		end else if (rx_end) begin
			rx_ptr_reg <= rx_ptr_reg + step_of(size_reg);
			rx_cnt_reg <= rx_cnt_dec;
		end else begin
			if (w_rx_ptr) rx_ptr_reg <= HWDATA_I;
			if (w_rx_cnt) rx_cnt_reg <= wd_cnt;
			if (w_rx_nptr) rx_nptr_reg <= HWDATA_I;
			if (w_rx_ncnt) rx_ncnt_reg <= wd_cnt;
		end
	end

	// Transmit channel pointers and counters
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			tx_ptr_reg <= PDMAC_PTR_RST;
			tx_cnt_reg <= PDMAC_CNT_RST;
			tx_nptr_reg <= PDMAC_PTR_RST;
			tx_ncnt_reg <= PDMAC_CNT_RST;
		end else if (tx_hit0 && (tx_ncnt_reg != PDMAC_CNT_RST)) begin
			tx_ptr_reg <= tx_nptr_reg;
			tx_cnt_reg <= tx_ncnt_reg;
			tx_ncnt_reg <= PDMAC_CNT_RST;
		end else if (tx_end) begin
			tx_ptr_reg <= tx_ptr_reg + step_of(size_reg);
			tx_cnt_reg <= tx_cnt_dec;
		end else begin
			if (w_tx_ptr) tx_ptr_reg <= HWDATA_I;
			if (w_tx_cnt) tx_cnt_reg <= wd_cnt;
			if (w_tx_nptr) tx_nptr_reg <= HWDATA_I;
			if (w_tx_ncnt) tx_ncnt_reg <= wd_cnt;
		end
	end

	// Done flags: set wins over the clearing counter write
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			rx_done_reg <= 1'b0;
			tx_done_reg <= 1'b0;
		end else begin
			if (rx_hit0) rx_done_reg <= 1'b1;
			else if (w_rx_cnt || w_rx_ncnt) rx_done_reg <= 1'b0;
			if (tx_hit0) tx_done_reg <= 1'b1;
			else if (w_tx_cnt || w_tx_ncnt) tx_done_reg <= 1'b0;
		end
	end

	// Exhausted outputs from flops; counters are zero in reset
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			rx_exh_reg <= 1'b1;
			tx_exh_reg <= 1'b1;
		end else begin
			rx_exh_reg <= rx_exh;
			tx_exh_reg <= tx_exh;
		end
	end

	// Memory master engine and peripheral strobes
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			state_reg <= PDMAC_ST_IDLE;
			dir_tx_reg <= 1'b0;
			m_req_reg <= 1'b0;
			m_write_reg <= 1'b0;
			m_addr_reg <= PDMAC_PTR_RST;
			m_wdata_reg <= 32'h0000_0000;
			tx_data_reg <= 32'h0000_0000;
			rx_take_reg <= 1'b0;
			tx_load_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			rx_take_reg <= 1'b0;
			tx_load_reg <= 1'b0;
			if ((state_reg == PDMAC_ST_IDLE) && (rx_want || tx_want)) begin
				dir_tx_reg <= !rx_want;
				m_write_reg <= rx_want;
				m_addr_reg <= rx_want ? rx_ptr_reg : tx_ptr_reg;
				m_wdata_reg <= RX_DATA_I;
				rx_take_reg <= rx_want;
			end
			if (state_reg == PDMAC_ST_ADDR) m_req_reg <= 1'b1;
			if (xfer_end) begin
				m_req_reg <= 1'b0;
				if (dir_tx_reg) begin
					tx_data_reg <= M_RDATA_I;
					tx_load_reg <= 1'b1;
				end
			end
		end
	end

	// Output drive from flip-flops; HREADYOUT_O and HRESP_O tied constant
	assign HRDATA_O = rdata_reg;
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O = 1'b0;
	assign RX_TAKE_O = rx_take_reg;
	assign TX_DATA_O = tx_data_reg;
	assign TX_LOAD_O = tx_load_reg;
	assign M_ADDR_O = m_addr_reg;
	assign M_WRITE_O = m_write_reg;
	assign M_SIZE_O = size_reg;
	assign M_REQ_O = m_req_reg;
	assign M_WDATA_O = m_wdata_reg;
	assign RX_DONE_O = rx_done_reg;
	assign TX_DONE_O = tx_done_reg;
	assign RX_EXH_O = rx_exh_reg;
	assign TX_EXH_O = tx_exh_reg;

	// Checks
	AST_RX_ON: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) rx_on && !rx_off |=> rx_en_reg)
		else $error("receive enable not taken");
	AST_RX_OFF: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) rx_off |=> !rx_en_reg)
		else $error("receive disable not taken");
	AST_TX_BOTH: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		w_ctrl && HWDATA_I[PDMAC_BIT_TX_ON] && HWDATA_I[PDMAC_BIT_TX_OFF] |=> !tx_en_reg)
		else $error("transmit disable lost to enable");
	AST_TX_ON: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) tx_on |=> tx_en_reg)
		else $error("transmit enable not taken");
	AST_TX_OFF: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) tx_off |=> !tx_en_reg)
		else $error("transmit disable not taken");
	AST_TX_STOP: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		(tx_cnt_reg == PDMAC_CNT_RST) && (state_reg == PDMAC_ST_IDLE) |=> !(dir_tx_reg && state_reg == PDMAC_ST_ADDR))
		else $error("transmit ran with zero count");
	AST_STEP: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		rx_end && !rx_hit0 |=> rx_ptr_reg == $past(rx_ptr_reg) + step_of($past(size_reg)))
		else $error("receive pointer step wrong");
	AST_TX_STEP: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		tx_end && !tx_hit0 |=> tx_ptr_reg == $past(tx_ptr_reg) + step_of($past(size_reg)))
		else $error("transmit pointer step wrong");
	AST_REQ_HOLD: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		M_REQ_O && !M_DONE_I |=> M_REQ_O && $stable(M_ADDR_O) && $stable(M_WRITE_O))
		else $error("memory request dropped early");
	AST_RELOAD: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		tx_hit0 && tx_ncnt_reg != PDMAC_CNT_RST |=> tx_ncnt_reg == PDMAC_CNT_RST && tx_cnt_reg == $past(tx_ncnt_reg))
		else $error("transmit chain reload wrong");
	AST_RX_RELOAD: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		rx_hit0 && rx_ncnt_reg != PDMAC_CNT_RST |=> rx_ncnt_reg == PDMAC_CNT_RST && rx_ptr_reg == $past(rx_nptr_reg))
		else $error("receive chain reload wrong");
	AST_DONE: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) rx_hit0 |=> rx_done_reg)
		else $error("receive done flag missed");
	AST_TX_DONE: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) tx_hit0 |=> tx_done_reg)
		else $error("transmit done flag missed");
	AST_CLR: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I) w_tx_ncnt && !tx_hit0 |=> !tx_done_reg)
		else $error("transmit done not cleared");
	AST_STAT: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
		rd_take && a_off == PDMAC_OFF_STAT |=> HRDATA_O == {23'h0, $past(tx_en_reg), 7'h0, $past(rx_en_reg)})
		else $error("status read wrong");
	COV_RX_XFER: cover property (@(posedge CORE_CLK_I) rx_end);
	COV_TX_CHAIN: cover property (@(posedge CORE_CLK_I) tx_hit0 && tx_ncnt_reg != PDMAC_CNT_RST);
	COV_RX_EXH: cover property (@(posedge CORE_CLK_I) rx_hit0 && rx_ncnt_reg == PDMAC_CNT_RST);
	COV_TX_LOAD: cover property (@(posedge CORE_CLK_I) tx_load_reg);
endmodule

/* src/pdmac_pkg.sv */
/*
 Package for the peripheral DMA channel pair: register offsets, field
 positions, reset values and bus encodings shared by the design.
 Assumes a 32-bit AHB-Lite register bus and a 32-bit memory master port.
*/
package pdmac_pkg;
	// Register byte offsets
	localparam logic [11:0] PDMAC_OFF_RX_PTR = 12'h100;
	localparam logic [11:0] PDMAC_OFF_RX_CNT = 12'h104;
	localparam logic [11:0] PDMAC_OFF_TX_PTR = 12'h108;
	localparam logic [11:0] PDMAC_OFF_TX_CNT = 12'h10c;
	localparam logic [11:0] PDMAC_OFF_RX_NPTR = 12'h110;
	localparam logic [11:0] PDMAC_OFF_RX_NCNT = 12'h114;
	localparam logic [11:0] PDMAC_OFF_TX_NPTR = 12'h118;
	localparam logic [11:0] PDMAC_OFF_TX_NCNT = 12'h11c;
	localparam logic [11:0] PDMAC_OFF_CTRL = 12'h120;
	localparam logic [11:0] PDMAC_OFF_STAT = 12'h124;
	localparam logic [11:0] PDMAC_OFF_SIZE = 12'h128;
	localparam logic [11:0] PDMAC_OFF_FLAGS = 12'h12c;
	// Control and status field positions
	localparam int PDMAC_BIT_RX_ON = 0;
	localparam int PDMAC_BIT_RX_OFF = 1;
	localparam int PDMAC_BIT_TX_ON = 8;
	localparam int PDMAC_BIT_TX_OFF = 9;
	// Flag register field positions
	localparam int PDMAC_BIT_RX_DONE = 0;
	localparam int PDMAC_BIT_RX_EXH = 1;
	localparam int PDMAC_BIT_TX_DONE = 2;
	localparam int PDMAC_BIT_TX_EXH = 3;
	// Counter width and reset values
	localparam int PDMAC_CNT_W = 16;
	localparam logic [31:0] PDMAC_PTR_RST = 32'h0000_0000;
	localparam logic [15:0] PDMAC_CNT_RST = 16'h0000;
	// Transfer size codes (AHB hsize encoding)
	localparam logic [1:0] PDMAC_SZ_BYTE = 2'h0;
	localparam logic [1:0] PDMAC_SZ_HALF = 2'h1;
	localparam logic [1:0] PDMAC_SZ_WORD = 2'h2;
	localparam logic [1:0] PDMAC_SZ_RST = 2'h0;
	// AHB transfer types
	localparam logic [1:0] PDMAC_HTRANS_IDLE = 2'h0;
	localparam logic [1:0] PDMAC_HTRANS_NONSEQ = 2'h2;
	// Master engine states
	typedef enum logic [1:0] {
		PDMAC_ST_IDLE = 2'b00,
		PDMAC_ST_ADDR = 2'b01,
		PDMAC_ST_DATA = 2'b10
	} pdmac_state_e;
endpackage

/* verif/pdmac_partner.sv */
/*
 Far-side model of the DMA pair: a serial peripheral and a memory.
 Assumes the bench arms each direction and picks the memory speed.
*/
`timescale 1ns/1ps
module pdmac_partner (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rx_arm_i,
	input wire logic tx_arm_i,
	input wire logic slow_i,
	input wire logic rx_take_i,
	output logic rx_ready_o,
	output logic [31:0] rx_data_o,
	output logic tx_ready_o,
	input wire logic m_req_i,
	input wire logic [31:0] m_addr_i,
	output logic [31:0] m_rdata_o,
	output logic m_done_o
);
	logic [31:0] word_reg;
	logic busy_reg;
	logic [1:0] wait_reg;
	// Peripheral data is junk while no word is offered
	assign rx_data_o = rx_ready_o ? word_reg : ~word_reg;
	assign tx_ready_o = tx_arm_i;
	// Peripheral offers a fresh word while armed, drops it once taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_ready_o <= 1'b0;
			word_reg <= 32'h1000_0000;
		end else if (rx_take_i) begin
			rx_ready_o <= 1'b0;
			word_reg <= word_reg + 32'h1;
		end else begin
			rx_ready_o <= rx_arm_i;
		end
	end
	// Memory answers after one or four cycles; read data churns otherwise
	always_ff @(posedge clk_i) begin
		m_done_o <= 1'b0;
		m_rdata_o <= ~m_rdata_o;
		if (rst_i) begin
			busy_reg <= 1'b0;
			wait_reg <= 2'h0;
			m_rdata_o <= 32'h0;
		end else if (busy_reg && wait_reg == 2'h0) begin
			busy_reg <= 1'b0;
			m_done_o <= 1'b1;
			m_rdata_o <= m_addr_i ^ 32'h5a5a_0000;
		end else if (busy_reg) begin
			wait_reg <= wait_reg - 2'h1;
		end else if (m_req_i && !m_done_o) begin
			busy_reg <= 1'b1;
			wait_reg <= slow_i ? 2'h3 : 2'h0;
		end
	end
endmodule

/* verif/peripheral_dma_channel_pair_bench.sv */
/*
 Self-checking bench for the DMA pair: register file, control, chained
 receive run in word size and transmit runs in every size. Assumes the partner model.
*/
`timescale 1ns/1ps
module peripheral_dma_channel_pair_bench import pdmac_pkg::*; ;
	logic clk, rst, hsel, hwrite, rx_arm, tx_arm, slow, rd_ph;
	logic [31:0] haddr, hwdata, hrdata, tx_data, m_addr, m_wdata, m_rdata, rx_data, r, p, q, t, u, step;
	logic [1:0] htrans, m_size, sz;
	logic [2:0] hsize;
	logic hreadyout, hresp, rx_take, tx_load, m_write, m_req, m_done, rx_ready, tx_ready;
	logic rx_done, rx_exh, tx_done, tx_exh;
	int miscompares, total_checks, i, seed;
	logic [31:0] exp_rd[$], exp_mw[$], exp_tx[$];
	logic [31:0] cw[10] = '{32'h1, 32'h0, 32'h100, 32'h3, 32'h1, 32'h2, 32'h300, 32'h100, 32'h200, 32'hffff_fcfc};
	logic [31:0] cs[10] = '{32'h1, 32'h1, 32'h101, 32'h100, 32'h101, 32'h100, 32'h0, 32'h100, 32'h0, 32'h0};
	// Device and far side
	pdmac_top u_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
		.HWRITE_I(hwrite), .HSIZE_I(hsize), .HREADY_I(hreadyout), .HWDATA_I(hwdata), .HRDATA_O(hrdata),
		.HREADYOUT_O(hreadyout), .HRESP_O(hresp), .RX_READY_I(rx_ready), .RX_DATA_I(rx_data),
		.RX_TAKE_O(rx_take), .TX_READY_I(tx_ready), .TX_DATA_O(tx_data), .TX_LOAD_O(tx_load),
		.M_ADDR_O(m_addr), .M_WRITE_O(m_write), .M_SIZE_O(m_size), .M_REQ_O(m_req), .M_WDATA_O(m_wdata),
		.M_RDATA_I(m_rdata), .M_DONE_I(m_done), .RX_DONE_O(rx_done), .RX_EXH_O(rx_exh),
		.TX_DONE_O(tx_done), .TX_EXH_O(tx_exh));
	pdmac_partner u_far (.clk_i(clk), .rst_i(rst), .rx_arm_i(rx_arm), .tx_arm_i(tx_arm), .slow_i(slow),
		.rx_take_i(rx_take), .rx_ready_o(rx_ready), .rx_data_o(rx_data), .tx_ready_o(tx_ready),
		.m_req_i(m_req), .m_addr_i(m_addr), .m_rdata_o(m_rdata), .m_done_o(m_done));
	// Clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// One single-word bus transfer, held until hready is seen
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= PDMAC_HTRANS_NONSEQ;
		haddr <= {20'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= PDMAC_HTRANS_IDLE;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_rd.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// Wait until every noted memory write and transmit load has shown
	task automatic drain;
		int n;
		n = 0;
		while (exp_mw.size() + exp_tx.size() != 0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		repeat (6) @(posedge clk);
		check("pending", 32'(exp_mw.size() + exp_tx.size()), 32'h0);
	endtask
	// Monitor: compares each result with the oldest note
	always @(posedge clk) begin
		if (rd_ph && hreadyout) check("hrdata", hrdata, exp_rd.pop_front());
		if (rd_ph && hreadyout) check("hresp", {31'h0, hresp}, 32'h0);
		if (m_done) check("m size", {30'h0, m_size}, {30'h0, sz});
		if (rst) rd_ph <= 1'b0;
		else if (hreadyout) rd_ph <= hsel & htrans[1] & !hwrite;
		if (m_done && m_write) begin
			check("rx addr", m_addr, exp_mw.pop_front());
			check("rx data", m_wdata, exp_mw.pop_front());
		end
		if (tx_load) check("tx data", tx_data, exp_tx.pop_front());
	end
	// Watchdog
	initial begin
		#80000;
		miscompares++;
		conclude();
	end
	// Main sequence
	initial begin
		seed = 86640;
		{rst, hsel, hwrite, rx_arm, tx_arm, slow} = 6'h20;
		{haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// Reset values
		for (i = 0; i < 11; i++) rd(12'h100 + 12'(4 * i), 32'h0);
		rd(PDMAC_OFF_FLAGS, 32'ha);
		bus(1'b1, PDMAC_OFF_SIZE, 32'h3);
		rd(PDMAC_OFF_SIZE, 32'h0);
		// Pointers keep 32 bits, counters 16
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			bus(1'b1, 12'h100 + 12'(4 * i), r);
			rd(12'h100 + 12'(4 * i), i[0] ? {16'h0, r[15:0]} : r);
			bus(1'b1, 12'h100 + 12'(4 * i), 32'h0);
		end
		bus(1'b1, 12'h200, $random(seed));
		rd(12'h200, 32'h0);
		rd(PDMAC_OFF_CTRL, 32'h0);
		// Enable and disable commands seen in status
		for (i = 0; i < 10; i++) begin
			bus(1'b1, PDMAC_OFF_CTRL, cw[i]);
			rd(PDMAC_OFF_STAT, cs[i]);
		end
		// Receive chain: two words, then one word in the next buffer
		p = $random(seed) & 32'hffff_fff0;
		q = $random(seed) & 32'hffff_fff0;
		sz = PDMAC_SZ_WORD;
		bus(1'b1, PDMAC_OFF_SIZE, {30'h0, PDMAC_SZ_WORD});
		bus(1'b1, PDMAC_OFF_RX_PTR, p);
		bus(1'b1, PDMAC_OFF_RX_CNT, 32'h2);
		bus(1'b1, PDMAC_OFF_RX_NPTR, q);
		bus(1'b1, PDMAC_OFF_RX_NCNT, 32'h1);
		bus(1'b1, PDMAC_OFF_CTRL, 32'h1);
		for (i = 0; i < 3; i++) begin
			exp_mw.push_back(i < 2 ? p + 32'(4 * i) : q);
			exp_mw.push_back(32'h1000_0000 + 32'(i));
		end
		rx_arm <= 1'b1;
		drain();
		rx_arm <= 1'b0;
		rd(PDMAC_OFF_RX_CNT, 32'h0);
		rd(PDMAC_OFF_RX_PTR, q + 32'h4);
		rd(PDMAC_OFF_RX_NCNT, 32'h0);
		rd(PDMAC_OFF_STAT, 32'h1);
		rd(PDMAC_OFF_FLAGS, 32'hb);
		check("rx done", {31'h0, rx_done}, 32'h1);
		check("rx exh", {31'h0, rx_exh}, 32'h1);
		bus(1'b1, PDMAC_OFF_RX_CNT, 32'h0);
		@(negedge clk);
		check("rx done clear", {31'h0, rx_done}, 32'h0);
		bus(1'b1, PDMAC_OFF_CTRL, 32'h2);
		// Transmit in byte, half and word size, memory speed alternating
		for (i = 0; i < 3; i++) begin
			t = $random(seed) & 32'hffff_fff0;
			u = $random(seed) & 32'hffff_fff0;
			step = 32'h1 << i;
			sz = 2'(i);
			slow <= i[0];
			bus(1'b1, PDMAC_OFF_SIZE, 32'(i));
			bus(1'b1, PDMAC_OFF_TX_PTR, t);
			bus(1'b1, PDMAC_OFF_TX_CNT, 32'h2);
			bus(1'b1, PDMAC_OFF_TX_NPTR, u);
			bus(1'b1, PDMAC_OFF_TX_NCNT, 32'h1);
			bus(1'b1, PDMAC_OFF_CTRL, 32'h100);
			exp_tx.push_back(t ^ 32'h5a5a_0000);
			exp_tx.push_back((t + step) ^ 32'h5a5a_0000);
			exp_tx.push_back(u ^ 32'h5a5a_0000);
			tx_arm <= 1'b1;
			drain();
			tx_arm <= 1'b0;
			rd(PDMAC_OFF_TX_PTR, u + step);
			rd(PDMAC_OFF_TX_CNT, 32'h0);
			rd(PDMAC_OFF_TX_NCNT, 32'h0);
			check("tx done", {31'h0, tx_done}, 32'h1);
			check("tx exh", {31'h0, tx_exh}, 32'h1);
			bus(1'b1, PDMAC_OFF_CTRL, 32'h200);
		end
		repeat (4) @(posedge clk);
		conclude();
	end
endmodule
